/* File: rtl/wgs_defs.svh */
// Constants of the waveform generator shutdown and polarity block:
// register byte offsets, field positions, reset values and counts.
// Assumes inclusion by bare name from the package and design files.
`ifndef WGS_DEFS_SVH
`define WGS_DEFS_SVH

`define WGS_ADDR_W 5
`define WGS_OFS_CTRL 5'h00
`define WGS_OFS_POL 5'h04
`define WGS_OFS_RISE 5'h08
`define WGS_OFS_FALL 5'h0C
`define WGS_OFS_SDS 5'h10
`define WGS_OFS_SRC 5'h14

`define WGS_CTRL_EN_BIT 7
`define WGS_CTRL_CS_BIT 0
`define WGS_POL_IN_BIT 5
`define WGS_SDS_SD_BIT 7
`define WGS_SDS_REN_BIT 6
`define WGS_SDS_PAIR_BD_OVERRIDE_LEVEL_HI 5
`define WGS_SDS_PAIR_BD_OVERRIDE_LEVEL_LO 4
`define WGS_SDS_PAIR_AC_OVERRIDE_LEVEL_HI 3
`define WGS_SDS_PAIR_AC_OVERRIDE_LEVEL_LO 2

`define WGS_DB_W 6
`define WGS_SRC_W 5
`define WGS_LS_RST 2'h1
`define WGS_DB_RST 6'h00
`define WGS_LS_ONE 2'h3
`define WGS_LS_ZERO 2'h2
`define WGS_LS_TRI 2'h1
`define WGS_LS_IDLE 2'h0

`endif

/* File: rtl/wgs_pkg.sv */
// Types of the waveform generator shutdown and polarity block.
// Assumes wgs_defs.svh is on the include path.
`include "wgs_defs.svh"

package wgs_pkg;

    typedef enum logic [2:0] {
        WGS_RUN = 3'b001,
        WGS_SHUT = 3'b010,
        WGS_EDGE = 3'b100
    } wgs_state_t;

    typedef struct packed {
        logic ack;
        logic [7:0] rdata;
        logic en;
        logic cs;
        logic [3:0] pol;
        logic [`WGS_DB_W-1:0] rise;
        logic [`WGS_DB_W-1:0] fall;
        logic sd;
        logic ren;
        logic [1:0] pair_bd_override_level;
        logic [1:0] pair_ac_override_level;
        logic [`WGS_SRC_W-1:0] srcen;
        wgs_state_t st;
        logic in_prev;
        logic [3:0] out;
        logic [3:0] oe;
    } wgs_regs_t;

    typedef struct packed {
        logic run;
        logic [`WGS_DB_W-1:0] cnt;
    } wgs_dly_t;

endpackage

/* File: rtl/wgs_dly_if.sv */
// Link between the shutdown control and one dead-band delay counter.
// Assumes one instance per counter, all signals in the ref_clk_in domain.
`timescale 1ns/1ps
`include "wgs_defs.svh"

interface wgs_dly_if;
    logic start;
    logic tick;
    logic [`WGS_DB_W-1:0] count;
    logic done;
    modport ctl (output start, output tick, output count, input done);
    modport cnt (input start, input tick, input count, output done);
endinterface

/* File: rtl/wgs_dly.sv */
// Dead-band delay counter: counts generator clock ticks after a start.
// Assumes start is a one-cycle pulse and tick is synchronous.
`timescale 1ns/1ps
`include "wgs_defs.svh"

module wgs_dly
    import wgs_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    wgs_dly_if.cnt dly
);
    wgs_dly_t s;
    wgs_dly_t nxt_s;

    always_comb begin
        nxt_s = s;
        // A new start always reloads, even over a count still running
        if (dly.start) begin
            nxt_s.run = (dly.count != `WGS_DB_RST);
            nxt_s.cnt = dly.count;
        end else if (s.run && dly.tick) begin
            nxt_s.cnt = s.cnt - 6'h01;
            if (s.cnt == 6'h01) begin
                nxt_s.run = 1'b0;
            end
        end
    end

    // A zero count is done at once, so no added delay
    assign dly.done = dly.start ? (dly.count == `WGS_DB_RST) : !s.run;

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s <= '{run: 1'b0, cnt: 6'h00};
        end else begin
            s <= nxt_s;
        end
    end

endmodule

/* File: rtl/wgs_top.sv */
// Shutdown, polarity and dead-band control of a four-output waveform
// generator, with its registers on an Avalon-MM slave.
// Assumes all inputs synchronous to ref_clk_in; trip inputs active low.
`timescale 1ns/1ps
`include "wgs_defs.svh"

module wgs_top
    import wgs_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic [`WGS_ADDR_W-1:0] address_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [31:0] writedata_in,
    input wire logic [3:0] byteenable_in,
    output logic [31:0] readdata_out,
    output logic waitrequest_out,
    input wire logic gen_in_in,
    input wire logic alt_tick_in,
    input wire logic [3:0] wave_data_in,
    input wire logic ext_pin_trip_b_in,
    input wire logic timer_trip_b_in,
    input wire logic comp_one_trip_b_in,
    input wire logic comp_two_trip_b_in,
    input wire logic logic_cell_trip_b_in,
    output logic wave_out_a_out,
    output logic wave_out_a_oe_out,
    output logic wave_out_b_out,
    output logic wave_out_b_oe_out,
    output logic wave_out_c_out,
    output logic wave_out_c_oe_out,
    output logic wave_out_d_out,
    output logic wave_out_d_oe_out
);
    localparam wgs_regs_t REGS_RST = '{
        ack: 1'b0, rdata: 8'h00, en: 1'b0, cs: 1'b0, pol: 4'h0,
        rise: `WGS_DB_RST, fall: `WGS_DB_RST, sd: 1'b0, ren: 1'b0,
        pair_bd_override_level: `WGS_LS_RST, pair_ac_override_level: `WGS_LS_RST, srcen: 5'h00,
        st: WGS_RUN, in_prev: 1'b0, out: 4'h0, oe: 4'h0
    };

    wgs_regs_t s;
    wgs_regs_t nxt_s;
    wgs_dly_if ac_dly ();
    wgs_dly_if bd_dly ();

    logic [`WGS_SRC_W-1:0] src_b;
    logic trip;
    logic cond;
    logic rise_evt;
    logic req;
    logic acc;
    logic wr;
    logic wr_sds;
    logic sw_set;
    logic sw_clr;
    logic gen_tick;

    assign src_b = {logic_cell_trip_b_in, comp_two_trip_b_in,
                    comp_one_trip_b_in, timer_trip_b_in, ext_pin_trip_b_in};
    // Low level on an enabled source trips, no edge needed
    assign trip = |(s.srcen & ~src_b);
    assign rise_evt = gen_in_in && !s.in_prev;

    // One wait state: the request is taken on the second edge
    assign req = read_in || write_in;
    assign acc = req && s.ack;
    assign waitrequest_out = req && !s.ack;
    assign wr = write_in && s.ack && byteenable_in[0];
    assign wr_sds = wr && (address_in == `WGS_OFS_SDS);
    assign sw_set = wr_sds && writedata_in[`WGS_SDS_SD_BIT];
    assign sw_clr = wr_sds && !writedata_in[`WGS_SDS_SD_BIT];
    // Equals the flag's next value, so state and flag move on one edge
    assign cond = trip || sw_set || (s.sd && !sw_clr && !s.ren);
    assign gen_tick = s.cs ? alt_tick_in : 1'b1;

    assign ac_dly.tick = gen_tick;
    assign bd_dly.tick = gen_tick;
    // Pair A/C goes inactive on its falling transition, B/D on its rising
    assign ac_dly.count = s.fall;
    assign bd_dly.count = s.rise;
    assign ac_dly.start = (s.st == WGS_RUN) && cond;
    assign bd_dly.start = ac_dly.start;

    wgs_dly u_ac_dly (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .dly(ac_dly.cnt)
    );

    wgs_dly u_bd_dly (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .dly(bd_dly.cnt)
    );

    function automatic logic [7:0] reg_read(input wgs_regs_t r,
                                            input logic [4:0] a,
                                            input logic gin);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            `WGS_OFS_CTRL: begin
                v[`WGS_CTRL_EN_BIT] = r.en;
                v[`WGS_CTRL_CS_BIT] = r.cs;
            end
            `WGS_OFS_POL: begin
                v[3:0] = r.pol;
                v[`WGS_POL_IN_BIT] = gin;
            end
            `WGS_OFS_RISE: v[5:0] = r.rise;
            `WGS_OFS_FALL: v[5:0] = r.fall;
            `WGS_OFS_SDS: v = {r.sd, r.ren, r.pair_bd_override_level, r.pair_ac_override_level, 2'b00};
            `WGS_OFS_SRC: v[4:0] = r.srcen;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    always_comb begin
        logic [1:0] lvl;
        logic dn;
        lvl = 2'b00;
        dn = 1'b0;
        nxt_s = s;
        nxt_s.ack = req && !s.ack;
        nxt_s.in_prev = gen_in_in;
        if (read_in && !s.ack) begin
            nxt_s.rdata = reg_read(s, address_in, gen_in_in);
        end
        if (wr) begin
            case (address_in)
                `WGS_OFS_CTRL: begin
                    nxt_s.en = writedata_in[`WGS_CTRL_EN_BIT];
                    nxt_s.cs = writedata_in[`WGS_CTRL_CS_BIT];
                end
                `WGS_OFS_POL: nxt_s.pol = writedata_in[3:0];
                `WGS_OFS_RISE: nxt_s.rise = writedata_in[5:0];
                `WGS_OFS_FALL: nxt_s.fall = writedata_in[5:0];
                `WGS_OFS_SDS: begin
                    nxt_s.ren = writedata_in[`WGS_SDS_REN_BIT];
                    nxt_s.pair_bd_override_level = writedata_in[5:4];
                    nxt_s.pair_ac_override_level = writedata_in[3:2];
                end
                `WGS_OFS_SRC: nxt_s.srcen = writedata_in[4:0];
                default: nxt_s.en = s.en;
            endcase
        end
        // A trip or a software set wins over any clear in the same cycle
        if (trip || sw_set) begin
            nxt_s.sd = 1'b1;
        end else if (sw_clr || s.ren) begin
            nxt_s.sd = 1'b0;
        end
        case (s.st)
            WGS_RUN: begin
                if (cond) begin
                    nxt_s.st = WGS_SHUT;
                end
            end
            WGS_SHUT: begin
                if (!cond) begin
                    nxt_s.st = WGS_EDGE;
                end
            end
            WGS_EDGE: begin
                if (cond) begin
                    nxt_s.st = WGS_SHUT;
                end else if (rise_evt) begin
                    nxt_s.st = WGS_RUN;
                end
            end
            default: nxt_s.st = WGS_SHUT;
        endcase
        for (int i = 0; i < 4; i++) begin
            lvl = i[0] ? nxt_s.pair_bd_override_level : nxt_s.pair_ac_override_level;
            dn = i[0] ? bd_dly.done : ac_dly.done;
            if (!nxt_s.en) begin
                nxt_s.out[i] = 1'b0;
                nxt_s.oe[i] = 1'b0;
            end else if (nxt_s.st == WGS_RUN) begin
                nxt_s.out[i] = wave_data_in[i] ^ nxt_s.pol[i];
                nxt_s.oe[i] = 1'b1;
            end else begin
                nxt_s.oe[i] = 1'b1;
                case (lvl)
                    `WGS_LS_ONE: nxt_s.out[i] = 1'b1;
                    `WGS_LS_ZERO: nxt_s.out[i] = 1'b0;
                    `WGS_LS_TRI: begin
                        nxt_s.out[i] = 1'b0;
                        nxt_s.oe[i] = 1'b0;
                    end
                    default: begin
                        nxt_s.out[i] = dn ? nxt_s.pol[i] :
                            (wave_data_in[i] ^ nxt_s.pol[i]);
                    end
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s <= REGS_RST;
        end else begin
            s <= nxt_s;
        end
    end

    assign readdata_out = {24'h000000, s.rdata};
    assign wave_out_a_out = s.out[0];
    assign wave_out_b_out = s.out[1];
    assign wave_out_c_out = s.out[2];
    assign wave_out_d_out = s.out[3];
    assign wave_out_a_oe_out = s.oe[0];
    assign wave_out_b_oe_out = s.oe[1];
    assign wave_out_c_oe_out = s.oe[2];
    assign wave_out_d_oe_out = s.oe[3];

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    a_pol_normal: assert property (
        (s.en && s.st == WGS_RUN) |->
        (s.out == ($past(wave_data_in) ^ s.pol)))
        else $error("run output does not follow data and polarity");

    a_in_status: assert property (
        (read_in && !s.ack && address_in == `WGS_OFS_POL) |=>
        (readdata_out[`WGS_POL_IN_BIT] == $past(gen_in_in)))
        else $error("input status bit does not show generator input");

    a_dead_hold: assert property (
        (!wr && !acc) |=> ($stable(s.rise) && $stable(s.fall)))
        else $error("dead-band count changed without a write");

    a_trip_sets: assert property (
        trip |=> (s.sd && s.st != WGS_RUN))
        else $error("active trip did not set shutdown");

    a_sw_set_flag: assert property (
        (sw_set && !s.en) |=> s.sd)
        else $error("shutdown write ignored while disabled");

    a_auto_clear: assert property (
        (s.sd && s.ren && !trip && !sw_set) |=> !s.sd)
        else $error("auto-restart did not clear flag");

    a_manual_hold: assert property (
        (s.sd && !s.ren && !sw_clr && !trip) |=> s.sd)
        else $error("flag cleared without software or auto-restart");

    sequence s_clear_seen;
        s.st == WGS_SHUT && !trip && !sw_set && (s.ren || sw_clr);
    endsequence

    sequence s_edge_seen;
        s.st == WGS_EDGE && rise_evt && !trip && !s.sd && !sw_set;
    endsequence

    a_hold_edge: assert property (
        s_clear_seen |=> (s.st == WGS_EDGE && !s.sd))
        else $error("override released before an input edge");

    a_resume: assert property (
        s_edge_seen |=> (s.st == WGS_RUN))
        else $error("no resume on generator rising edge");

    a_no_spurious: assert property (
        (s.st == WGS_RUN && !trip && !s.sd && !sw_set) |=>
        (s.st == WGS_RUN))
        else $error("shutdown without an enabled cause");

    a_ac_level: assert property (
        (s.en && s.st != WGS_RUN && s.pair_ac_override_level == `WGS_LS_ONE) |->
        (s.out[0] && s.out[2] && s.oe[0] && s.oe[2]))
        else $error("pair A/C not driven high in shutdown");

    a_bd_float: assert property (
        (s.en && s.st != WGS_RUN && s.pair_bd_override_level == `WGS_LS_TRI) |->
        (!s.oe[1] && !s.oe[3]))
        else $error("pair B/D not floated in shutdown");

    a_dly_zero: assert property (
        (ac_dly.start && ac_dly.count == `WGS_DB_RST) |-> ac_dly.done)
        else $error("zero dead-band count added delay");

    a_dly_wait: assert property (
        (ac_dly.start && ac_dly.count != `WGS_DB_RST) |=> !ac_dly.done)
        else $error("dead-band ended at once with nonzero count");

endmodule

/* File: tb/wgs_stage.sv */
// Model of the switching stage that hangs on the four generator pins.
// Assumes pull-downs on the gate lines, so a floated pin reads low.
`timescale 1ns/1ps

module wgs_stage (
    input wire logic [3:0] drv_in,
    input wire logic [3:0] oe_in,
    output logic [3:0] gate_out
);
    // A released pin falls to the pull-down, never keeps its last value
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            gate_out[i] = oe_in[i] ? drv_in[i] : 1'b0;
        end
    end
endmodule

/* File: tb/testbench.sv */
// Self-checking bench of the shutdown, polarity and dead-band block.
// Assumes a pulled-down switch stage; the bus waits as long as asked.
`timescale 1ns/1ps
`include "wgs_defs.svh"

module testbench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [4:0] addr = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic wait_req;
    logic gen_in = 1'b0;
    logic tick = 1'b0;
    logic [3:0] wave = 4'hA;
    logic [4:0] trip_b = 5'h1F;
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
    logic [3:0] gate;
    logic [31:0] rd_val;
    logic [1:0] bd;
    logic [1:0] ac;
    int mismatches = 0;
    int n_checks = 0;
    logic [1:0] codes [3] = '{2'h3, 2'h2, 2'h1};
    logic [7:0] rst_q [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h14, 8'h00};
    logic [4:0] row_a [7] = '{5'h04, 5'h08, 5'h0C, 5'h14, 5'h10, 5'h18,
        5'h00};
    logic [7:0] row_d [7] = '{8'hFF, 8'hFF, 8'hC5, 8'hFF, 8'h3F, 8'hFF,
        8'h80};
    logic [7:0] row_q [7] = '{8'h0F, 8'h3F, 8'h05, 8'h1F, 8'h3C, 8'h00,
        8'h80};

    always #2.5 clk = ~clk;

    wgs_top u_wgs_top (
        .ref_clk_in(clk), .rst_b_in(rst_b), .address_in(addr),
        .read_in(rd), .write_in(wr), .writedata_in(wdata),
        .byteenable_in(4'hF), .readdata_out(rdata),
        .waitrequest_out(wait_req), .gen_in_in(gen_in),
        .alt_tick_in(tick), .wave_data_in(wave),
        .ext_pin_trip_b_in(trip_b[0]), .timer_trip_b_in(trip_b[1]),
        .comp_one_trip_b_in(trip_b[2]), .comp_two_trip_b_in(trip_b[3]),
        .logic_cell_trip_b_in(trip_b[4]),
        .wave_out_a_out(pin_out[0]), .wave_out_a_oe_out(pin_oe[0]),
        .wave_out_b_out(pin_out[1]), .wave_out_b_oe_out(pin_oe[1]),
        .wave_out_c_out(pin_out[2]), .wave_out_c_oe_out(pin_oe[2]),
        .wave_out_d_out(pin_out[3]), .wave_out_d_oe_out(pin_oe[3])
    );

    wgs_stage u_wgs_stage (.drv_in(pin_out), .oe_in(pin_oe),
        .gate_out(gate));

    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
            mismatches++;
        end
    endtask

    // The request stands until the rising edge that sees waitrequest low;
    // read data are taken at that edge and only then is it released
    task automatic bus(input logic is_rd, input logic [4:0] a,
                       input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= {24'h0, d};
        rd <= is_rd;
        wr <= ~is_rd;
        do begin
            @(posedge clk);
        end while (wait_req !== 1'b0);
        rd_val = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic pin_chk(input logic [7:0] e);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("pins", {24'h0, e}, {24'h0, pin_oe, gate});
    endtask

    task automatic set_in(input logic [4:0] t, input logic g);
        @(posedge clk);
        trip_b <= t;
        gen_in <= g;
    endtask

    // Output enables in the high nibble, gate levels in the low one
    function automatic logic [7:0] ovr(input logic [1:0] b,
                                       input logic [1:0] a);
        logic [1:0] c;
        for (int i = 0; i < 4; i++) begin
            c = (i % 2 == 1) ? b : a;
            ovr[i + 4] = c[1];
            ovr[i] = (c == 2'h3);
        end
    endfunction

    initial begin
        #200000;
        mismatches++;
        give_verdict();
    end

    initial begin
        repeat (4) @(posedge clk);
        chk("pins in reset", 32'h0, {24'h0, pin_oe, gate});
        rst_b <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, 5'(i * 4), 8'h00);
            chk("reset value", {24'h0, rst_q[i]}, rd_val);
        end
        for (int i = 0; i < 7; i++) begin
            bus(1'b0, row_a[i], row_d[i]);
            bus(1'b1, row_a[i], 8'h00);
            chk("readback", {24'h0, row_q[i]}, rd_val);
        end
        for (int p = 0; p < 16; p++) begin
            bus(1'b0, `WGS_OFS_POL, 8'(p));
            pin_chk({4'hF, wave ^ 4'(p)});
        end
        set_in(5'h1F, 1'b1);
        bus(1'b1, `WGS_OFS_POL, 8'h00);
        chk("input status", 32'h2F, rd_val);
        for (int s = 0; s < 5; s++) begin
            bd = codes[s % 3];
            ac = codes[(s + 1) % 3];
            bus(1'b0, `WGS_OFS_SRC, 8'(1 << s));
            bus(1'b0, `WGS_OFS_SDS, {2'b01, bd, ac, 2'b00});
            set_in(~(5'h1 << ((s + 1) % 5)), 1'b0);
            pin_chk(8'hF5);
            set_in(~(5'h1 << s), 1'b0);
            pin_chk(ovr(bd, ac));
            bus(1'b1, `WGS_OFS_SDS, 8'h00);
            chk("flag set", {24'h0, 2'b11, bd, ac, 2'b00}, rd_val);
            set_in(5'h1F, 1'b0);
            repeat (4) @(posedge clk);
            bus(1'b1, `WGS_OFS_SDS, 8'h00);
            chk("flag auto", {24'h0, 2'b01, bd, ac, 2'b00}, rd_val);
            pin_chk(ovr(bd, ac));
            set_in(5'h1F, 1'b1);
            pin_chk(8'hF5);
            set_in(5'h1F, 1'b0);
        end
        bus(1'b0, `WGS_OFS_CTRL, 8'h00);
        bus(1'b0, `WGS_OFS_SRC, 8'h01);
        bus(1'b0, `WGS_OFS_SDS, 8'hBC);
        bus(1'b1, `WGS_OFS_SDS, 8'h00);
        chk("flag while off", 32'hBC, rd_val);
        pin_chk(8'h00);
        bus(1'b0, `WGS_OFS_CTRL, 8'h80);
        pin_chk(8'hFF);
        set_in(5'h1E, 1'b0);
        bus(1'b0, `WGS_OFS_SDS, 8'h3C);
        bus(1'b1, `WGS_OFS_SDS, 8'h00);
        chk("clear refused", 32'hBC, rd_val);
        set_in(5'h1F, 1'b0);
        repeat (4) @(posedge clk);
        bus(1'b1, `WGS_OFS_SDS, 8'h00);
        chk("no auto clear", 32'hBC, rd_val);
        bus(1'b0, `WGS_OFS_SDS, 8'h3C);
        pin_chk(8'hFF);
        set_in(5'h1F, 1'b1);
        pin_chk(8'hF5);
        bus(1'b0, `WGS_OFS_RISE, 8'h04);
        bus(1'b0, `WGS_OFS_FALL, 8'h0C);
        bus(1'b0, `WGS_OFS_POL, 8'h0A);
        bus(1'b0, `WGS_OFS_SDS, 8'h40);
        wave <= 4'hF;
        set_in(5'h1E, 1'b0);
        pin_chk(8'hF5);
        repeat (4) @(posedge clk);
        pin_chk(8'hFF);
        repeat (8) @(posedge clk);
        pin_chk(8'hFA);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        chk("pins in reset", 32'h0, {24'h0, pin_oe, gate});
        rst_b <= 1'b1;
        bus(1'b1, `WGS_OFS_SDS, 8'h00);
        chk("reset value", 32'h14, rd_val);
        // Zero counts after reset: inactive level with no added delay
        bus(1'b0, `WGS_OFS_SDS, 8'h00);
        bus(1'b0, `WGS_OFS_CTRL, 8'h80);
        bus(1'b0, `WGS_OFS_SRC, 8'h01);
        pin_chk(8'hF0);
        // Alternate generator clock: the count only moves on ticks
        bus(1'b0, `WGS_OFS_RISE, 8'h02);
        bus(1'b0, `WGS_OFS_CTRL, 8'h81);
        set_in(5'h1F, 1'b0);
        bus(1'b0, `WGS_OFS_SDS, 8'h00);
        set_in(5'h1F, 1'b1);
        set_in(5'h1E, 1'b1);
        pin_chk(8'hFA);
        repeat (2) begin
            @(posedge clk);
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
        end
        pin_chk(8'hF0);
        give_verdict();
    end
endmodule
